// ### rtl/sig_cmp.sv
/*
 * Signature compare engine: steps pins and ranges, asks the digitizer for
 * each pair of signatures, judges each pin against the tolerance, keeps a
 * sorted list of differing pins and reports pass or fail. AXI4-Lite slave.
 * Assumes the digitizer runs on sys_clk and answers each measure request
 * with exactly one hundred sample strobes.
 */
`timescale 1ns/100ps
module sig_cmp
   import sig_cmp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic meas_start,
   output logic [5:0] pin_sel,
   output logic [1:0] range_sel,
   output logic ab_view,
   input wire logic smp_valid,
   input wire logic [7:0] smp_ref,
   input wire logic [7:0] smp_sus,
   output logic [3:0] range_led,
   output logic pass_lamp,
   output logic fail_lamp
);
   typedef struct packed {
      state_e st;
      logic [31:0] cfg;
      logic [31:0] dflt;
      logic [3:0] ren;
      logic [5:0] pin;
      logic [1:0] rng;
      logic [6:0] cyc;
      logic [6:0] smp;
      logic [7:0] maxd;
      logic [15:0] area;
      logic anyd;
      logic cont;
      logic pass;
      logic fail;
      logic abort;
      entry_s hinfo;
      entry_s [RES_DEPTH-1:0] res;
      logic [6:0] rcnt;
      logic [5:0] rsel;
      logic aw_h;
      logic [7:0] aw_a;
      logic w_h;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } state_s;

   state_s q, d;

   // ---------------------------------------------------------------
   // setup fields and the judgement of the pin just measured
   // ---------------------------------------------------------------
   logic [6:0] tol;
   logic [6:0] cycles;
   logic [5:0] last_pin;
   logic [7:0] sdiff;
   logic [7:0] sexcess;
   logic pin_diff;
   entry_s cand;
   entry_s [RES_DEPTH-1:0] ins;
   logic [RES_DEPTH-1:0] gt;

   assign tol = q.cfg[CFG_TOL_LSB +: 7];
   assign cycles = q.cfg[CFG_CYC_LSB +: 7];
   assign last_pin = q.cfg[CFG_PINS_LSB +: 6];
   // unsigned magnitude of one sample pair
   assign sdiff = (smp_sus > smp_ref) ? smp_sus - smp_ref : smp_ref - smp_sus;
   // per-sample contribution beyond tolerance, zero when within it
   assign sexcess = (sdiff > {1'b0, tol}) ? sdiff - {1'b0, tol} : 8'h00;
   assign pin_diff = q.maxd > {1'b0, tol};
   assign cand.pin = q.pin;
   assign cand.rng = q.rng;
   assign cand.dev = pin_diff ? q.maxd - {1'b0, tol} : 8'h00;
   assign cand.area = q.area;

   // ---------------------------------------------------------------
   // sorted insertion: each slot keeps, takes the new entry, or takes
   // its upper neighbour; ties keep older entries ahead
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < RES_DEPTH; gi++) begin : g_ins
         assign gt[gi] = (7'(gi) >= q.rcnt) || (cand.area > q.res[gi].area);
         if (gi == 0) begin : g_top
            assign ins[gi] = gt[gi] ? cand : q.res[gi];
         end else begin : g_rest
            assign ins[gi] = !gt[gi] ? q.res[gi] :
                             !gt[gi-1] ? cand : q.res[gi-1];
         end
      end
   endgenerate

   // next enabled range above cur, or the lowest one when from_start
   function automatic logic [2:0] next_rng(input logic [1:0] cur, input logic [3:0] en,
                                           input logic from_start);
      logic [2:0] r;
      r = 3'b000;
      for (int j = NRANGE - 1; j >= 0; j--) begin
         if (en[j] && (from_start || 2'(j) > cur)) begin
            r = {1'b1, 2'(j)};
         end
      end
      return r;
   endfunction

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // next state: bus slave, commands, sequencer
   // ---------------------------------------------------------------
   always_comb begin
      logic wr;
      logic [31:0] cw;
      logic [2:0] nr;
      logic [2:0] fr;
      logic eoc;
      d = q;
      wr = 1'b0;
      cw = 32'h0000_0000;
      nr = 3'b000;
      fr = next_rng(2'b00, q.ren, 1'b1);
      eoc = 1'b0;

      // address and data are captured independently, in either order
      if (awvalid && !q.aw_h) begin
         d.aw_h = 1'b1;
         d.aw_a = awaddr;
      end
      if (wvalid && !q.w_h) begin
         d.w_h = 1'b1;
         d.w_d = wdata;
         d.w_s = wstrb;
      end
      if (q.bv && bready) begin
         d.bv = 1'b0;
      end
      if (q.aw_h && q.w_h && !q.bv) begin
         wr = 1'b1;
         d.aw_h = 1'b0;
         d.w_h = 1'b0;
         d.bv = 1'b1;
         d.br = 2'b00;
         cw = q.w_s[0] ? q.w_d : 32'h0000_0000;
         unique case (q.aw_a)
            CTRL_OFS, DFLT_OFS, STAT_OFS, HALT_OFS, RDATA_OFS: ;
            RANGE_OFS: begin
               // a one in a lane toggles that enable, like a button press
               if (!(q.st inside {S_REQ, S_SMP, S_JUDGE, S_HALT})) begin
                  d.ren = q.ren ^ cw[3:0];
               end
            end
            CFG_OFS: begin
               // the setup is frozen while a run is under way
               if (!(q.st inside {S_REQ, S_SMP, S_JUDGE, S_HALT})) begin
                  d.cfg = merge(q.cfg, q.w_d, q.w_s) & 32'h3F7F_037F;
                  if (d.cfg[CFG_TOL_LSB +: 7] > TOL_MAX) begin
                     d.cfg[CFG_TOL_LSB +: 7] = TOL_MAX;
                  end
                  if (d.cfg[CFG_CYC_LSB +: 7] > CYC_MAX) begin
                     d.cfg[CFG_CYC_LSB +: 7] = CYC_MAX;
                  end
               end
            end
            RSEL_OFS: d.rsel = cw[5:0];
            default: d.br = 2'b10;
         endcase
      end

      // commands; a write that is not CTRL leaves cw unused here
      if (!wr || q.aw_a != CTRL_OFS) begin
         cw = 32'h0000_0000;
      end
      if (cw[CMD_STORE]) begin
         d.dflt = q.cfg;
      end
      if (cw[CMD_RECALL] && !(q.st inside {S_REQ, S_SMP, S_JUDGE, S_HALT})) begin
         d.cfg = q.dflt;
      end
      if (cw[CMD_EXIT]) begin
         d.rcnt = 7'h00;
      end

      // sequencer
      unique case (q.st)
         S_IDLE, S_DONE: begin
            if (cw[CMD_START] && fr[2]) begin
               d.st = S_REQ;
               d.pin = 6'h00;
               d.rng = fr[1:0];
               d.cyc = 7'h00;
               d.anyd = 1'b0;
               d.cont = 1'b0;
               d.pass = 1'b0;
               d.fail = 1'b0;
               d.abort = 1'b0;
               d.rcnt = 7'h00;
            end
         end
         S_REQ: begin
            d.st = S_SMP;
            d.smp = 7'h00;
            d.maxd = 8'h00;
            d.area = 16'h0000;
         end
         S_SMP: begin
            if (smp_valid) begin
               if (sdiff > q.maxd) begin
                  d.maxd = sdiff;
               end
               d.area = q.area + 16'(sexcess);
               d.smp = q.smp + 7'h01;
               if (q.smp == 7'(SAMPLES - 1)) begin
                  d.st = S_JUDGE;
               end
            end
         end
         S_JUDGE: begin
            d.st = S_REQ;
            if (pin_diff) begin
               d.anyd = 1'b1;
               d.res = ins;
               if (q.rcnt != 7'(RES_DEPTH)) begin
                  d.rcnt = q.rcnt + 7'h01;
               end
            end
            // advance position
            if (!q.cfg[CFG_ORDER_BIT]) begin
               nr = next_rng(q.rng, q.ren, 1'b0);
               if (nr[2]) begin
                  d.rng = nr[1:0];
               end else if (q.pin != last_pin) begin
                  d.pin = q.pin + 6'h01;
                  d.rng = fr[1:0];
               end else begin
                  eoc = 1'b1;
               end
            end else begin
               nr = next_rng(q.rng, q.ren, 1'b0);
               if (q.pin != last_pin) begin
                  d.pin = q.pin + 6'h01;
               end else if (nr[2]) begin
                  d.pin = 6'h00;
                  d.rng = nr[1:0];
               end else begin
                  eoc = 1'b1;
               end
            end
            if (eoc) begin
               d.pin = 6'h00;
               d.rng = fr[1:0];
               d.cyc = q.cyc + 7'h01;
               if (cycles == 7'h00) begin
                  if (d.anyd) begin
                     d.st = S_DONE;
                  end
               end else if (q.cyc + 7'h01 >= cycles) begin
                  d.st = S_DONE;
               end
            end
            if (pin_diff && q.cfg[CFG_STOP_BIT] && !q.cont) begin
               d.st = S_HALT;
               d.hinfo = cand;
            end
            if (d.st == S_DONE) begin
               d.fail = d.anyd;
               d.pass = !d.anyd && cycles != 7'h00;
            end
         end
         S_HALT: begin
            if (cw[CMD_CONT]) begin
               d.cont = 1'b1;
               d.st = (q.pin == 6'h00 && q.rng == fr[1:0] && q.cyc != 7'h00 &&
                       (cycles != 7'h00 && q.cyc >= cycles)) ? S_DONE : S_REQ;
               d.fail = d.st == S_DONE;
            end
         end
         default: d.st = S_IDLE;
      endcase

      // escape ends any run at once; the result so far stands
      if (cw[CMD_ESC] && q.st inside {S_REQ, S_SMP, S_JUDGE, S_HALT}) begin
         d.st = S_DONE;
         d.abort = 1'b1;
         d.pass = 1'b0;
         d.fail = d.anyd;
      end

      // read channel
      if (q.rv && rready) begin
         d.rv = 1'b0;
      end
      if (arvalid && !q.rv) begin
         d.rv = 1'b1;
         d.rr = 2'b00;
         unique case (araddr)
            CTRL_OFS: d.rd = 32'h0000_0000;
            RANGE_OFS: d.rd = {28'h000_0000, q.ren};
            CFG_OFS: d.rd = q.cfg;
            DFLT_OFS: d.rd = q.dflt;
            STAT_OFS: d.rd = {17'h0_0000, q.rcnt, 2'b00,
                              q.st == S_DONE, q.abort, q.fail, q.pass,
                              q.st == S_HALT, q.st inside {S_REQ, S_SMP, S_JUDGE}};
            HALT_OFS: d.rd = q.hinfo;
            RSEL_OFS: d.rd = {26'h000_0000, q.rsel};
            RDATA_OFS: d.rd = (7'(q.rsel) < q.rcnt) ? q.res[q.rsel] : 32'h0000_0000;
            default: begin
               d.rd = 32'h0000_0000;
               d.rr = 2'b10;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
         q.st <= S_IDLE;
         q.cfg <= CFG_RESET;
         q.dflt <= CFG_RESET;
         q.ren <= RANGE_RESET;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign awready = !q.aw_h;
   assign wready = !q.w_h;
   assign bvalid = q.bv;
   assign bresp = q.br;
   assign arready = !q.rv;
   assign rvalid = q.rv;
   assign rdata = q.rd;
   assign rresp = q.rr;
   assign meas_start = q.st == S_REQ;
   assign pin_sel = q.pin;
   assign range_sel = q.rng;
   assign ab_view = q.st inside {S_REQ, S_SMP, S_JUDGE, S_HALT};
   assign range_led = q.ren;
   assign pass_lamp = q.pass;
   assign fail_lamp = q.fail;
endmodule // sig_cmp

// ### rtl/sig_cmp_pkg.sv
/*
 * Package for the signature compare engine: register map, field positions,
 * reset values, sizes and the sequencer state encoding.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sig_cmp_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int SAMPLES = 100;          // samples per signature
   localparam int RES_DEPTH = 64;         // results list entries
   localparam int PIN_MAX = 64;
   localparam int NRANGE = 4;
   localparam logic [6:0] TOL_MAX = 7'h63;    // 99
   localparam logic [6:0] CYC_MAX = 7'h63;    // 99, zero means repeat until a cycle finds a difference
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] RANGE_OFS = 8'h04;
   localparam logic [7:0] CFG_OFS = 8'h08;
   localparam logic [7:0] DFLT_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] HALT_OFS = 8'h14;
   localparam logic [7:0] RSEL_OFS = 8'h18;
   localparam logic [7:0] RDATA_OFS = 8'h1C;
   // ---------------------------------------------------------------
   // command bits of CTRL (write only, self clearing)
   // ---------------------------------------------------------------
   localparam int CMD_START = 0;
   localparam int CMD_CONT = 1;
   localparam int CMD_ESC = 2;
   localparam int CMD_STORE = 3;
   localparam int CMD_EXIT = 4;
   localparam int CMD_RECALL = 5;
   // ---------------------------------------------------------------
   // setup word layout
   // ---------------------------------------------------------------
   localparam int CFG_TOL_LSB = 0;        // 7 bits
   localparam int CFG_STOP_BIT = 8;       // 1 = halt on difference
   localparam int CFG_ORDER_BIT = 9;      // 1 = all pins per range
   localparam int CFG_CYC_LSB = 16;       // 7 bits
   localparam int CFG_PINS_LSB = 24;      // 6 bits, pin count minus one
   localparam logic [31:0] CFG_RESET = 32'h1301_0000;  // 20 pins, 1 cycle
   localparam logic [3:0] RANGE_RESET = 4'h1;
   // ---------------------------------------------------------------
   // status word layout
   // ---------------------------------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_HALT = 1;
   localparam int ST_PASS = 2;
   localparam int ST_FAIL = 3;
   localparam int ST_ABORT = 4;
   localparam int ST_DONE = 5;
   localparam int ST_CNT_LSB = 8;         // 7-bit result count

   // result entry, also the halt information word
   typedef struct packed {
      logic [15:0] area;
      logic [7:0] dev;
      logic [1:0] rng;
      logic [5:0] pin;
   } entry_s;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_REQ = 3'b001,
      S_SMP = 3'b010,
      S_JUDGE = 3'b011,
      S_HALT = 3'b100,
      S_DONE = 3'b101
   } state_e;
endpackage

// ### dv/sig_cmp_checker.sv
/* port assertions for the compare engine, bound into every sig_cmp.
   assumes one clock, sys_clk, and a synchronous active-high rst. */
`timescale 1ns/100ps
module sig_cmp_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic meas_start,
   input wire logic [5:0] pin_sel,
   input wire logic [1:0] range_sel,
   input wire logic ab_view,
   input wire logic smp_valid,
   input wire logic [3:0] range_led,
   input wire logic pass_lamp,
   input wire logic fail_lamp
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [7:0] cnt_q;
   logic arm_q;
   // strobes since the last request; arm only inside a run, since escape may cut one short
   always_ff @(posedge sys_clk) begin
      if (rst || meas_start) cnt_q <= 8'h00;
      else if (smp_valid && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
      if (rst || !ab_view) arm_q <= 1'h0;
      else if (meas_start) arm_q <= 1'h1;
   end
   sequence both_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence read_taken;
      arvalid && arready;
   endsequence
   write_answer_a: assert property (both_taken |-> ##2 bvalid) else $error("write not answered");
   read_answer_a: assert property (read_taken |=> rvalid) else $error("read not answered");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   start_pulse_a: assert property (meas_start |=> !meas_start) else $error("long request");
   sel_stable_a: assert property (meas_start |=> ($stable(pin_sel) && $stable(range_sel))[*8])
      else $error("selection moved");
   strobe_count_a: assert property (meas_start && arm_q |-> cnt_q == 8'h64)
      else $error("request before all samples");
   view_on_a: assert property (meas_start |-> ab_view) else $error("view off in run");
   lamp_excl_a: assert property (!(pass_lamp && fail_lamp)) else $error("both lamps lit");
   reset_vals_a: assert property ($fell(rst) |-> range_led == 4'h1 && !pass_lamp && !fail_lamp)
      else $error("bad reset outputs");
endmodule // sig_cmp_checker

bind sig_cmp sig_cmp_checker sig_cmp_checker_inst (.sys_clk(sys_clk), .rst(rst),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .meas_start(meas_start), .pin_sel(pin_sel), .range_sel(range_sel),
   .ab_view(ab_view), .smp_valid(smp_valid), .range_led(range_led), .pass_lamp(pass_lamp),
   .fail_lamp(fail_lamp));

// ### dv/digitizer_model.sv
/* digitizer stand-in: answers each request with 100 sample pairs.
   assumes it shares sys_clk; dtab gives the per-pin difference. */
`timescale 1ns/100ps
module digitizer_model (
   input wire logic sys_clk,
   input wire logic meas_start,
   input wire logic [5:0] pin_sel,
   input wire logic slow,
   input wire logic [7:0] dtab [64],
   output logic smp_valid,
   output logic [7:0] smp_ref,
   output logic [7:0] smp_sus
);
   int k = 0;
   logic busy = 1'h0;
   logic ph = 1'h0;
   initial begin
      smp_valid = 1'h0;
      smp_ref = 8'h00;
      smp_sus = 8'hff;
   end
   // first three samples differ; pins with bit 1 set go below the reference
   always @(posedge sys_clk) begin
      ph <= ~ph;
      smp_valid <= 1'h0;
      smp_ref <= ~smp_ref; // lines churn between strobes so no stale value passes
      smp_sus <= ~smp_sus;
      if (meas_start) begin
         busy <= 1'h1;
         k <= 0;
      end else if (busy && !(slow && ph)) begin
         smp_valid <= 1'h1;
         smp_ref <= 8'(50 + k);
         smp_sus <= k > 2 ? 8'(50 + k) : pin_sel[1] ? 8'(50 + k - dtab[pin_sel]) :
            8'(50 + k + dtab[pin_sel]);
         k <= k + 1;
         if (k == 99) busy <= 1'h0;
      end
   end
endmodule // digitizer_model

// ### dv/test_sig_cmp.sv
/* self-checking bench for the compare engine: registers over AXI4-Lite,
   digitizer model on the sample side. assumes rtl/ and the bound checker. */
`timescale 1ns/100ps
module test_sig_cmp;
   import sig_cmp_pkg::*;
   logic sys_clk = 1'h0, rst = 1'h1, slow = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, v, rdata;
   logic [3:0] wstrb = 4'h0, range_led;
   logic [1:0] r, bresp, rresp, range_sel;
   logic awready, wready, bvalid, arready, rvalid, meas_start, ab_view;
   logic smp_valid, pass_lamp, fail_lamp;
   logic [5:0] pin_sel;
   logic [7:0] smp_ref, smp_sus;
   logic [7:0] dtab [64];
   logic [7:0] seq [$];
   int mismatches = 0, tests_run = 0, nmeas = 0;

   sig_cmp sig_cmp_inst (.sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .meas_start(meas_start), .pin_sel(pin_sel), .range_sel(range_sel), .ab_view(ab_view),
      .smp_valid(smp_valid), .smp_ref(smp_ref), .smp_sus(smp_sus), .range_led(range_led),
      .pass_lamp(pass_lamp), .fail_lamp(fail_lamp));
   digitizer_model digitizer_model_inst (.sys_clk(sys_clk), .meas_start(meas_start),
      .pin_sel(pin_sel), .slow(slow), .dtab(dtab), .smp_valid(smp_valid),
      .smp_ref(smp_ref), .smp_sus(smp_sus));

   // ------------------------------------------------------------
   // clock, request log, helpers
   // ------------------------------------------------------------
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (meas_start) begin
      nmeas++;
      seq.push_back({range_sel, pin_sel});
   end
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   function logic [31:0] cfg(int t, int s, int o, int c, int p);
      return {2'h0, p[5:0], 1'h0, c[6:0], 6'h00, o[0], s[0], 1'h0, t[6:0]};
   endfunction
   function logic [31:0] ent(int p, int d, int a);
      return {a[15:0], d[7:0], 2'h0, p[5:0]};
   endfunction
   // bus tasks look at the design mid-cycle and move inputs just after rising edges;
   // bready and rready rise a cycle after valid, so the slave must hold its answer
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb, hv;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(negedge sys_clk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hv = bvalid;
         hb = bvalid & bready;
         r = bresp;
         @(posedge sys_clk);
         if (ha) awvalid <= 1'h0;
         if (hw) wvalid <= 1'h0;
         if (hv && !hb) bready <= 1'h1;
      end while (!hb);
      bready <= 1'h0;
   endtask
   task rd(input logic [7:0] a);
      logic ha, hb, hv;
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(negedge sys_clk);
         ha = arvalid & arready;
         hv = rvalid;
         hb = rvalid & rready;
         v = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (ha) arvalid <= 1'h0;
         if (hv && !hb) rready <= 1'h1;
      end while (!hb);
      rready <= 1'h0;
   endtask
   task setd(input int a, input int b, input int c);
      for (int i = 0; i < 64; i++) dtab[i] <= i == 1 ? 8'(a) : i == 2 ? 8'(b) : i == 3 ? 8'(c) : 8'h00;
   endtask
   task go(input logic [31:0] c);
      wr(CFG_OFS, c);
      nmeas = 0;
      seq.delete();
      wr(CTRL_OFS, 32'h0000_0001 << CMD_START);
   endtask
   task wt;
      for (int i = 0; i < 5000; i++) begin
         rd(STAT_OFS);
         if (v[ST_DONE] || v[ST_HALT]) break;
      end
   endtask
   task res(input int i, input logic [31:0] e);
      wr(RSEL_OFS, 32'(i));
      rd(RDATA_OFS);
      chk("result", v, e);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd(CFG_OFS);
      chk("cfg", v, CFG_RESET);
      rd(DFLT_OFS);
      chk("default", v, CFG_RESET);
      rd(RANGE_OFS);
      chk("ranges", v, 32'h0000_0001);
      rd(8'h20);
      chk("unmapped read", r, 2'h2);
      wr(8'h24, 32'h0000_0001);
      chk("unmapped write", r, 2'h2);
   endtask
   task t_range;
      wr(RANGE_OFS, 32'h0000_0006);
      chk("leds", range_led, 4'h7);
      wr(RANGE_OFS, 32'h0000_0006);
      chk("leds", range_led, 4'h1);
   endtask
   task t_setup;
      wr(CFG_OFS, cfg(127, 0, 0, 127, 3));
      rd(CFG_OFS);
      chk("saturate", v, cfg(99, 0, 0, 99, 3));
      wr(CFG_OFS, cfg(7, 1, 1, 5, 3));
      wr(CTRL_OFS, 32'h0000_0001 << CMD_STORE);
      rd(DFLT_OFS);
      chk("stored", v, cfg(7, 1, 1, 5, 3));
      wr(CFG_OFS, cfg(0, 0, 0, 1, 3));
      wr(CTRL_OFS, 32'h0000_0001 << CMD_RECALL);
      rd(CFG_OFS);
      chk("recalled", v, cfg(7, 1, 1, 5, 3));
   endtask
   task t_all;
      setd(10, 5, 20);
      slow <= 1'h1;
      go(cfg(5, 0, 0, 1, 3));
      wt;
      chk("status", {v[14:8], v[5:0]}, {7'h02, 6'h28});
      chk("measures", nmeas, 4);
      chk("lamps", {pass_lamp, fail_lamp}, 2'h1);
      res(0, ent(3, 15, 45));
      res(1, ent(1, 5, 15));
      res(2, 32'h0000_0000);
      slow <= 1'h0;
   endtask
   task t_stop;
      go(cfg(5, 1, 0, 1, 3));
      wt;
      chk("halted", v[ST_HALT], 1'h1);
      chk("measures", nmeas, 2);
      rd(HALT_OFS);
      chk("halt info", v, ent(1, 5, 15));
      wr(CTRL_OFS, 32'h0000_0001 << CMD_CONT);
      wt;
      chk("status", v[5:2], 4'ha);
      chk("measures", nmeas, 4);
      wr(CTRL_OFS, 32'h0000_0001 << CMD_EXIT);
      rd(STAT_OFS);
      chk("count", v[14:8], 7'h00);
      res(0, 32'h0000_0000);
   endtask
   task t_order;
      setd(0, 0, 0);
      wr(RANGE_OFS, 32'h0000_0002);
      go(cfg(0, 0, 0, 3, 1));
      wt;
      chk("status", v[5:2], 4'h9);
      chk("measures", nmeas, 12);
      for (int i = 0; i < 4; i++) chk("order", seq[i], {2'(i % 2), 6'(i / 2)});
      go(cfg(0, 0, 1, 1, 1));
      wt;
      chk("lamps", {pass_lamp, fail_lamp}, 2'h2);
      for (int i = 0; i < 4; i++) chk("order", seq[i], {2'(i / 2), 6'(i % 2)});
   endtask
   task t_endless;
      go(cfg(0, 0, 0, 0, 1));
      for (int i = 0; i < 3000 && nmeas < 6; i++) @(posedge sys_clk);
      repeat (20) @(posedge sys_clk);
      wr(CTRL_OFS, 32'h0000_0001 << CMD_ESC);
      wt;
      chk("status", v[5:2], 4'hc);
      chk("repeats", nmeas >= 6, 1'h1);
      chk("pass lamp", pass_lamp, 1'h0);
      setd(1, 0, 0);
      go(cfg(0, 0, 0, 0, 1));
      wt;
      chk("status", v[5:2], 4'ha);
      chk("measures", nmeas, 4);
   endtask

   // watchdog: the whole run needs well under this many cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      t_reset;
      t_range;
      t_setup;
      t_all;
      t_stop;
      t_order;
      t_endless;
      complete_run;
   end
endmodule // test_sig_cmp
